/* rtl/fpt_pkg.sv */
package fpt_pkg;
   localparam int unsigned CLK_HZ           = 20_000_000;
   localparam int unsigned MS_PER_S         = 1000;
   localparam int unsigned CLK_PER_MS       = CLK_HZ / MS_PER_S;
   localparam int unsigned UPDATE_MS        = 100;
   localparam int unsigned UPDATE_CYCLES    = CLK_PER_MS * UPDATE_MS;
   localparam int unsigned NV_MS            = 1000;
   localparam int unsigned NV_UPDATES       = NV_MS / UPDATE_MS;
   localparam int unsigned CONFIRM_MS       = 2000;
   localparam int unsigned CONFIRM_CYCLES   = CLK_PER_MS * CONFIRM_MS;
   localparam int unsigned ACK_MS           = 2000;
   localparam int unsigned ACK_CYCLES       = CLK_PER_MS * ACK_MS;
   localparam int unsigned INTERVAL_MIN_MS  = 500;
   localparam int unsigned INTERVAL_MAX_MS  = 60000;
   localparam int unsigned CUTOFF_MAX       = 100;
   localparam int unsigned START_MAX        = 1000;
   localparam int unsigned HYST_TENTHS      = 10;
   localparam int unsigned TENTHS_FULL      = 1000;
   localparam int unsigned DAMP_MAX_S       = 99;
   localparam int unsigned SAMPLES_MAX      = 32;
   localparam int unsigned CHZ_PER_HZ       = 100;
   localparam int unsigned MPULSE_PER_PULSE = 1000;
   localparam int unsigned ADD_SCALE        =
      UPDATE_MS * MPULSE_PER_PULSE / (MS_PER_S * CHZ_PER_HZ);
   localparam int unsigned PERIOD_MAX       = 32'h0400_0000;
   localparam logic [15:0] VOLT_MIN_CODE    = 16'h0000;
   localparam logic [15:0] CURR_MIN_CODE    = 16'h3333;

   typedef enum logic {MEAS_COUNT, MEAS_WIDTH} fpt_meas_type;

   typedef enum logic [3:0] {
      SRC_NONE, SRC_FLOW_LO, SRC_FLOW_HI, SRC_FLOW_RANGE, SRC_MAIN_TOT,
      SRC_PILOT_TOT, SRC_TEMP_LO, SRC_TEMP_HI, SRC_TEMP_RANGE, SRC_DIAG,
      SRC_MANUAL
   } fpt_src_type;

   typedef struct packed {
      fpt_meas_type mode;
      logic [15:0]  interval_ms;
      logic [15:0]  cal_ppg;
      logic [23:0]  full_scale_chz;
      logic [6:0]   cutoff_tenths;
      logic [6:0]   damping_s;
      logic [5:0]   samples;
   } fpt_meas_cfg_type;

   typedef struct packed {
      logic        enable;
      logic [9:0]  start_tenths;
      logic [31:0] event_vol;
      logic [31:0] stop_vol;
   } fpt_tot_cfg_type;

   typedef struct packed {
      logic        flow_lo;
      logic        flow_hi;
      logic        temp_lo;
      logic        temp_hi;
      logic        rtd_fitted;
      logic [15:0] diag;
   } fpt_alarm_type;

   localparam fpt_meas_cfg_type MEAS_FACTORY = '{
      mode: MEAS_WIDTH, interval_ms: 16'h0FA0, cal_ppg: 16'h0001,
      full_scale_chz: 24'h00_2710, cutoff_tenths: 7'h00,
      damping_s: 7'h05, samples: 6'h05};
   localparam fpt_tot_cfg_type TOT_FACTORY = '{
      enable: 1'b0, start_tenths: 10'h000, event_vol: 32'h0000_0000,
      stop_vol: 32'h0000_0000};
endpackage

/* rtl/fpt_top.sv */
`timescale 1ns/100ps
module fpt_top #(
   parameter int unsigned P_MS_CYCLES      = fpt_pkg::CLK_PER_MS,
   parameter int unsigned P_UPDATE_CYCLES  = fpt_pkg::UPDATE_CYCLES,
   parameter int unsigned P_CONFIRM_CYCLES = fpt_pkg::CONFIRM_CYCLES,
   parameter int unsigned P_ACK_CYCLES     = fpt_pkg::ACK_CYCLES
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_reset_n,
   input  wire logic                      i_enable,
   input  wire logic                      i_pulse,
   input  wire logic                      i_cfg_load,
   input  wire fpt_pkg::fpt_meas_cfg_type i_meas_cfg,
   input  wire fpt_pkg::fpt_tot_cfg_type  i_main_cfg,
   input  wire fpt_pkg::fpt_tot_cfg_type  i_pilot_cfg,
   input  wire fpt_pkg::fpt_src_type      i_out_sel_a,
   input  wire fpt_pkg::fpt_src_type      i_out_sel_b,
   input  wire fpt_pkg::fpt_alarm_type    i_alarms,
   input  wire logic [31:0]               i_nv_total,
   input  wire logic                      i_accept,
   input  wire logic                      i_reset_sel,
   input  wire logic [15:0]               i_dac_volt,
   input  wire logic [15:0]               i_dac_curr,
   output logic [23:0]                    o_flow_chz,
   output logic                           o_cutoff,
   output logic [15:0]                    o_dac_volt,
   output logic [15:0]                    o_dac_curr,
   output logic [31:0]                    o_main_total,
   output logic [31:0]                    o_pilot_total,
   output logic                           o_main_event,
   output logic                           o_pilot_event,
   output logic                           o_nv_store,
   output logic [31:0]                    o_nv_total,
   output logic                           o_confirm_shown,
   output logic                           o_ack_shown,
   output logic [1:0]                     o_iso_out
);
   if (P_MS_CYCLES < 1 || P_UPDATE_CYCLES < 1 || P_CONFIRM_CYCLES < 1
       || P_ACK_CYCLES < 1)
   begin : g_bad
      $error("fpt_top: cycle counts must be at least one");
   end

   typedef enum {RS_IDLE, RS_CONFIRM, RS_ACK} fpt_rst_type;

   function automatic logic at_or_above(input logic [23:0] rate,
                                        input logic [9:0]  tenths,
                                        input logic [23:0] fs);
      logic [47:0] lhs;
      logic [47:0] rhs;
      lhs = {24'h00_0000, rate} * 48'd1000;
      rhs = {38'h0, tenths} * {24'h00_0000, fs};
      return lhs >= rhs;
   endfunction

   fpt_pkg::fpt_meas_cfg_type meas_q;
   fpt_pkg::fpt_tot_cfg_type  tot_cfg_q [2];
   fpt_pkg::fpt_src_type      sel_q [2];
   logic        pulse_prev_q;
   logic [31:0] ms_cnt_q;
   logic [15:0] win_ms_q;
   logic [31:0] pulses_q;
   logic [31:0] per_q;
   logic [23:0] samp_q [fpt_pkg::SAMPLES_MAX];
   logic [4:0]  wr_q;
   logic [28:0] sum_q;
   logic        cut_q;
   logic [23:0] flow_q;
   logic [31:0] upd_cnt_q;
   logic [31:0] tot_q [2];
   logic [31:0] frac_q [2];
   logic        restored_q;
   logic [3:0]  nv_cnt_q;
   fpt_rst_type rs_q;
   logic [31:0] rs_tmr_q;
   logic        rs_sel_q;
   logic [1:0]  manual_q;

   wire        rise    = i_pulse & ~pulse_prev_q;
   wire        ms_tick = ms_cnt_q == P_MS_CYCLES - 1;
   // Interval clamped so an out-of-range setting cannot divide badly
   wire [15:0] interval = (meas_q.interval_ms < 16'(fpt_pkg::INTERVAL_MIN_MS))
                        ? 16'(fpt_pkg::INTERVAL_MIN_MS)
                        : (meas_q.interval_ms > 16'(fpt_pkg::INTERVAL_MAX_MS))
                        ? 16'(fpt_pkg::INTERVAL_MAX_MS) : meas_q.interval_ms;
   wire        win_end   = ms_tick && (win_ms_q >= interval - 16'd1);
   wire        is_width  = meas_q.mode == fpt_pkg::MEAS_WIDTH;
   wire        per_sat   = per_q >= fpt_pkg::PERIOD_MAX;
   wire [31:0] cnt_rate  = pulses_q * 32'(fpt_pkg::CHZ_PER_HZ * fpt_pkg::MS_PER_S)
                         / {16'h0000, interval};
   wire [31:0] wid_rate  = (per_q == 32'h0000_0000) ? 32'h0000_0000
                         : 32'(fpt_pkg::CLK_HZ * fpt_pkg::CHZ_PER_HZ) / per_q;
   // Width mode samples each rising edge; a stalled sensor reads as zero flow
   wire        samp_v    = is_width ? (rise | (per_sat & ~rise)) : win_end;
   wire [23:0] raw       = is_width ? (per_sat ? 24'h00_0000 : wid_rate[23:0])
                         : cnt_rate[23:0];
   wire        filt_on   = is_width && meas_q.damping_s != 7'h00;
   wire [5:0]  n_samp    = (meas_q.samples == 6'h00) ? 6'h01
                         : (meas_q.samples > 6'(fpt_pkg::SAMPLES_MAX))
                         ? 6'(fpt_pkg::SAMPLES_MAX) : meas_q.samples;
   wire [4:0]  old_idx   = wr_q - n_samp[4:0];
   wire [28:0] sum_d     = sum_q + {5'h00, raw} - {5'h00, samp_q[old_idx]};
   wire [28:0] mean      = sum_d / {23'h00_0000, n_samp};
   wire [23:0] rate_sel  = filt_on ? mean[23:0] : raw;
   wire [9:0]  cut_lvl   = {3'b000, meas_q.cutoff_tenths};
   wire [9:0]  cut_exit  = cut_lvl + 10'(fpt_pkg::HYST_TENTHS);
   wire        cut_d     = cut_q ? !at_or_above(rate_sel, cut_exit, meas_q.full_scale_chz)
                         : !at_or_above(rate_sel, cut_lvl, meas_q.full_scale_chz);
   wire        upd_tick  = upd_cnt_q == P_UPDATE_CYCLES - 1;
   wire [31:0] upg       = (meas_q.cal_ppg == 16'h0000) ? 32'(fpt_pkg::MPULSE_PER_PULSE)
                         : {16'h0000, meas_q.cal_ppg} * 32'(fpt_pkg::MPULSE_PER_PULSE);
   wire        accept    = i_accept && i_enable;
   wire        clr_main  = rs_q == RS_CONFIRM && accept && !rs_sel_q;
   wire        clr_pilot = rs_q == RS_CONFIRM && accept && rs_sel_q;
   wire [1:0]  clr       = {clr_pilot, clr_main};
   wire        rs_expire = rs_tmr_q == 32'h0000_0000;
   wire        temp_ok   = i_alarms.rtd_fitted;
   wire        flow_rng  = !i_alarms.flow_lo && !i_alarms.flow_hi;
   wire        temp_rng  = temp_ok && !i_alarms.temp_lo && !i_alarms.temp_hi;
   wire        diag_any  = |i_alarms.diag;
   wire [1:0]  reach;
   wire [1:0]  run;
   wire [1:0]  upd;
   wire [1:0]  src_on;
   wire [31:0] acc [2];

   for (genvar t = 0; t < 2; t++)
   begin : g_tot
      wire [31:0] ev  = tot_cfg_q[t].event_vol;
      wire [31:0] stp = tot_cfg_q[t].stop_vol;
      assign reach[t] = ev != 32'h0000_0000 && tot_q[t] >= ev;
      assign run[t]   = tot_cfg_q[t].enable && !cut_q
                      && at_or_above(flow_q, tot_cfg_q[t].start_tenths,
                                     meas_q.full_scale_chz)
                      && !(stp != 32'h0000_0000 && tot_q[t] >= stp);
      assign acc[t]   = frac_q[t] + {8'h00, flow_q} * 32'(fpt_pkg::ADD_SCALE);
      assign upd[t]   = clr[t] || (upd_tick && run[t]);
   end

   for (genvar o = 0; o < 2; o++)
   begin : g_out
      logic sel_on;
      always_comb
      begin
         unique case (sel_q[o])
            fpt_pkg::SRC_NONE:       sel_on = 1'b0;
            fpt_pkg::SRC_FLOW_LO:    sel_on = i_alarms.flow_lo;
            fpt_pkg::SRC_FLOW_HI:    sel_on = i_alarms.flow_hi;
            fpt_pkg::SRC_FLOW_RANGE: sel_on = flow_rng;
            fpt_pkg::SRC_MAIN_TOT:   sel_on = o_main_event;
            fpt_pkg::SRC_PILOT_TOT:  sel_on = o_pilot_event;
            fpt_pkg::SRC_TEMP_LO:    sel_on = temp_ok && i_alarms.temp_lo;
            fpt_pkg::SRC_TEMP_HI:    sel_on = temp_ok && i_alarms.temp_hi;
            fpt_pkg::SRC_TEMP_RANGE: sel_on = temp_rng;
            fpt_pkg::SRC_DIAG:       sel_on = diag_any;
            fpt_pkg::SRC_MANUAL:     sel_on = 1'b1;
            default:                 sel_on = 1'b0;
         endcase
      end
      assign src_on[o] = sel_on;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         meas_q       <= fpt_pkg::MEAS_FACTORY;
         tot_cfg_q[0] <= fpt_pkg::TOT_FACTORY;
         tot_cfg_q[1] <= fpt_pkg::TOT_FACTORY;
         sel_q[0]     <= fpt_pkg::SRC_NONE;
         sel_q[1]     <= fpt_pkg::SRC_NONE;
      end
      else if (i_enable && i_cfg_load)
      begin
         meas_q       <= i_meas_cfg;
         tot_cfg_q[0] <= i_main_cfg;
         tot_cfg_q[1] <= i_pilot_cfg;
         sel_q[0]     <= i_out_sel_a;
         sel_q[1]     <= i_out_sel_b;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pulse_prev_q <= 1'b0;
         ms_cnt_q     <= 32'h0000_0000;
         win_ms_q     <= 16'h0000;
         pulses_q     <= 32'h0000_0000;
         per_q        <= 32'h0000_0000;
      end
      else if (i_enable)
      begin
         pulse_prev_q <= i_pulse;
         ms_cnt_q     <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'd1;
         win_ms_q     <= win_end ? 16'h0000 : win_ms_q + 16'(ms_tick);
         pulses_q     <= win_end ? 32'(rise) : pulses_q + 32'(rise);
         per_q        <= rise ? 32'd1 : per_sat ? 32'd1 : per_q + 32'd1;
      end
   end

   // Sample history is flushed on any config load so the mean never mixes
   // windows of different length
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < fpt_pkg::SAMPLES_MAX; i++)
            samp_q[i] <= 24'h00_0000;
         wr_q  <= 5'h00;
         sum_q <= 29'h0000_0000;
      end
      else if (i_enable && i_cfg_load)
      begin
         for (int i = 0; i < fpt_pkg::SAMPLES_MAX; i++)
            samp_q[i] <= 24'h00_0000;
         wr_q  <= 5'h00;
         sum_q <= 29'h0000_0000;
      end
      else if (i_enable && samp_v && filt_on)
      begin
         samp_q[wr_q] <= raw;
         wr_q         <= wr_q + 5'd1;
         sum_q        <= sum_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cut_q      <= 1'b0;
         flow_q     <= 24'h00_0000;
         o_dac_volt <= fpt_pkg::VOLT_MIN_CODE;
         o_dac_curr <= fpt_pkg::CURR_MIN_CODE;
      end
      else if (i_enable)
      begin
         if (samp_v)
         begin
            cut_q  <= cut_d;
            flow_q <= cut_d ? 24'h00_0000 : rate_sel;
         end
         o_dac_volt <= cut_q ? fpt_pkg::VOLT_MIN_CODE : i_dac_volt;
         o_dac_curr <= cut_q ? fpt_pkg::CURR_MIN_CODE : i_dac_curr;
      end
   end

   // Main total is restored once, on the first enabled cycle after reset
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         upd_cnt_q  <= 32'h0000_0000;
         restored_q <= 1'b0;
         nv_cnt_q   <= 4'h0;
         o_nv_store <= 1'b0;
         o_nv_total <= 32'h0000_0000;
         for (int t = 0; t < 2; t++)
         begin
            tot_q[t]  <= 32'h0000_0000;
            frac_q[t] <= 32'h0000_0000;
         end
      end
      else if (i_enable)
      begin
         upd_cnt_q  <= upd_tick ? 32'h0000_0000 : upd_cnt_q + 32'd1;
         restored_q <= 1'b1;
         o_nv_store <= 1'b0;
         if (upd_tick)
         begin
            nv_cnt_q <= (nv_cnt_q == 4'(fpt_pkg::NV_UPDATES - 1)) ? 4'h0
                      : nv_cnt_q + 4'h1;
            if (nv_cnt_q == 4'(fpt_pkg::NV_UPDATES - 1))
            begin
               o_nv_store <= 1'b1;
               o_nv_total <= tot_q[0];
            end
         end
         for (int t = 0; t < 2; t++)
         begin
            if (clr[t])
            begin
               tot_q[t]  <= 32'h0000_0000;
               frac_q[t] <= 32'h0000_0000;
            end
            else if (upd[t])
            begin
               tot_q[t]  <= tot_q[t] + acc[t] / upg;
               frac_q[t] <= acc[t] % upg;
            end
         end
         if (!restored_q)
            tot_q[0] <= i_nv_total;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rs_q     <= RS_IDLE;
         rs_tmr_q <= 32'h0000_0000;
         rs_sel_q <= 1'b0;
      end
      else if (i_enable)
      begin
         unique case (rs_q)
            RS_IDLE:
               if (accept)
               begin
                  rs_q     <= RS_CONFIRM;
                  rs_tmr_q <= P_CONFIRM_CYCLES - 1;
                  rs_sel_q <= i_reset_sel;
               end
            RS_CONFIRM:
               if (accept)
               begin
                  rs_q     <= RS_ACK;
                  rs_tmr_q <= P_ACK_CYCLES - 1;
               end
               else if (rs_expire)
                  rs_q <= RS_IDLE;
               else
                  rs_tmr_q <= rs_tmr_q - 32'd1;
            RS_ACK:
               if (rs_expire)
                  rs_q <= RS_IDLE;
               else
                  rs_tmr_q <= rs_tmr_q - 32'd1;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         manual_q        <= 2'b00;
         o_iso_out       <= 2'b00;
         o_flow_chz      <= 24'h00_0000;
         o_cutoff        <= 1'b0;
         o_main_total    <= 32'h0000_0000;
         o_pilot_total   <= 32'h0000_0000;
         o_main_event    <= 1'b0;
         o_pilot_event   <= 1'b0;
         o_confirm_shown <= 1'b0;
         o_ack_shown     <= 1'b0;
      end
      else if (i_enable)
      begin
         for (int o = 0; o < 2; o++)
         begin
            // Manual latch survives a switch to any source other than SRC_NONE
            if (sel_q[o] == fpt_pkg::SRC_MANUAL)
               manual_q[o] <= 1'b1;
            else if (sel_q[o] == fpt_pkg::SRC_NONE)
               manual_q[o] <= 1'b0;
            o_iso_out[o] <= (sel_q[o] != fpt_pkg::SRC_NONE)
                          && (src_on[o] || manual_q[o]);
         end
         o_flow_chz      <= flow_q;
         o_cutoff        <= cut_q;
         o_main_total    <= tot_q[0];
         o_pilot_total   <= tot_q[1];
         o_main_event    <= reach[0];
         o_pilot_event   <= reach[1];
         o_confirm_shown <= rs_q == RS_CONFIRM;
         o_ack_shown     <= rs_q == RS_ACK;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   chk_pilot_hold: assert property (
      i_enable && restored_q && !upd[1] |=> tot_q[1] == $past(tot_q[1]))
      else $error("pilot total moved off the update period");
   chk_pilot_zero: assert property (
      !restored_q |-> tot_q[1] == 32'h0000_0000)
      else $error("pilot total not zero after power-up");
   chk_below_start: assert property (
      i_enable && restored_q && !run[0] && !clr[0] |=> tot_q[0] == $past(tot_q[0]))
      else $error("main total moved while not running");
   chk_event_off: assert property (
      i_enable && tot_cfg_q[0].event_vol == 32'h0000_0000 |=> !o_main_event)
      else $error("event raised with zero event volume");
   chk_reset_confirm: assert property (
      rs_q == RS_CONFIRM && accept |=> rs_q == RS_ACK && tot_q[rs_sel_q] == 0)
      else $error("confirmed reset did not clear total");
   chk_out_disabled: assert property (
      i_enable && sel_q[0] == fpt_pkg::SRC_NONE |=> !o_iso_out[0])
      else $error("disabled output energized");
   chk_diag_on: assert property (
      i_enable && sel_q[1] == fpt_pkg::SRC_DIAG && diag_any |=> o_iso_out[1])
      else $error("diagnostic output not energized");
   chk_cut_zero: assert property (
      cut_q |-> flow_q == 24'h00_0000)
      else $error("flow not forced to zero while cut off");
   chk_cut_dac: assert property (
      i_enable && cut_q |=> o_dac_curr == fpt_pkg::CURR_MIN_CODE && o_dac_volt == 0)
      else $error("analog codes not at minimum while cut off");
   chk_cut_hyst: assert property (
      i_enable && samp_v && cut_q
      && !at_or_above(rate_sel, cut_exit, meas_q.full_scale_chz) |=> cut_q)
      else $error("cut-off left inside hysteresis band");
   chk_filter_bypass: assert property (
      i_enable && samp_v && !is_width && !cut_d |=> flow_q == $past(raw))
      else $error("count mode flow was filtered");
endmodule

/* verif/fpt_sensor_model.sv */
`timescale 1ns/100ps
module fpt_sensor_model (
   input  wire logic        i_ref_clk,
   input  wire logic [15:0] i_period,
   output logic             o_pulse
);
   logic [15:0] cnt_q = 16'h0000;
   logic        pulse_q = 1'b0;
   assign o_pulse = pulse_q;
   // Period 0 parks the line low, as a stopped paddle would
   always_ff @(posedge i_ref_clk)
   begin
      if (i_period == 16'h0000 || cnt_q + 16'h0001 >= i_period)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
      pulse_q <= (i_period != 16'h0000) && (cnt_q < (i_period >> 1));
   end
endmodule

/* verif/fpt_top_tb.sv */
`timescale 1ns/100ps
module fpt_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, load = 1'b0, acc = 1'b0, rsel = 1'b0, pulse;
   logic ena = 1'b1, nvs;
   logic [31:0] nvt = 32'h0000_2710, nvo;
   logic [15:0] dvin = 16'h1234, dcin = 16'h5678;
   logic [15:0] period = 16'h0000;
   fpt_pkg::fpt_meas_cfg_type meas = fpt_pkg::MEAS_FACTORY;
   fpt_pkg::fpt_tot_cfg_type  mcfg = fpt_pkg::TOT_FACTORY;
   fpt_pkg::fpt_tot_cfg_type  pcfg = fpt_pkg::TOT_FACTORY;
   fpt_pkg::fpt_src_type      sela = fpt_pkg::SRC_NONE;
   fpt_pkg::fpt_src_type      selb = fpt_pkg::SRC_NONE;
   fpt_pkg::fpt_alarm_type    alm = '0;
   logic [23:0] flow;
   logic        cut, mev, pev, conf, ack;
   logic [15:0] dv, dc;
   logic [31:0] mtot, ptot;
   logic [1:0]  iso;
   int n_fail = 0, comparisons = 0, cyc = 0, n_store = 0, n0 = 0;
   initial forever #25 clk = ~clk;
   fpt_sensor_model fpt_sensor_model_inst (.i_ref_clk(clk), .i_period(period), .o_pulse(pulse));
   fpt_top #(.P_MS_CYCLES(4), .P_UPDATE_CYCLES(20), .P_CONFIRM_CYCLES(50), .P_ACK_CYCLES(50))
   fpt_top_inst (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_enable(ena), .i_pulse(pulse),
      .i_cfg_load(load), .i_meas_cfg(meas), .i_main_cfg(mcfg), .i_pilot_cfg(pcfg),
      .i_out_sel_a(sela), .i_out_sel_b(selb), .i_alarms(alm), .i_nv_total(nvt),
      .i_accept(acc), .i_reset_sel(rsel), .i_dac_volt(dvin), .i_dac_curr(dcin),
      .o_flow_chz(flow), .o_cutoff(cut), .o_dac_volt(dv), .o_dac_curr(dc),
      .o_main_total(mtot), .o_pilot_total(ptot), .o_main_event(mev), .o_pilot_event(pev),
      .o_nv_store(nvs), .o_nv_total(nvo), .o_confirm_shown(conf), .o_ack_shown(ack),
      .o_iso_out(iso));
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // Config ports are only taken on the strobe, so every change goes through here
   task cfg_load();
      @(posedge clk);
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      settle(3);
   endtask
   task press();
      @(posedge clk);
      acc <= 1'b1;
      @(posedge clk);
      acc <= 1'b0;
   endtask
   task close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (nvs)
         n_store++;
      if (cyc == 60000)
      begin
         n_fail++;
         close_out();
      end
   end
   initial
   begin
      settle(5);
      chk(dc, 32'h0000_3333);
      chk(ptot, 32'h0000_0000);
      @(posedge clk);
      rst_n <= 1'b1;
      meas.full_scale_chz <= 24'h98_9680;
      meas.damping_s <= 7'h00;
      period <= 16'h0190;
      cfg_load();
      settle(200);
      n0 = n_store;
      settle(1000);
      chk(flow, 32'h004C_4B40);
      chk(cut, 32'h0000_0000);
      chk({mtot, nvo}, {32'h0000_2710, 32'h0000_2710});
      chk(n_store - n0, 32'h0000_0005);
      @(posedge clk);
      mcfg.enable <= 1'b1;
      mcfg.event_vol <= 32'h0000_0001;
      pcfg.enable <= 1'b1;
      pcfg.start_tenths <= 10'h3E8;
      sela <= fpt_pkg::SRC_MAIN_TOT;
      cfg_load();
      settle(100);
      chk(mtot % 32'h0000_1388, 32'h0000_0000);
      chk(mtot > 32'h0000_2710, 32'h0000_0001);
      chk({mev, pev, ptot}, {2'b10, 32'h0000_0000});
      chk(iso, 32'h0000_0001);
      @(posedge clk);
      mcfg.enable <= 1'b0;
      cfg_load();
      press();
      settle(3);
      chk(conf, 32'h0000_0001);
      press();
      settle(2);
      chk({ack, mtot}, {1'b1, 32'h0000_0000});
      settle(40);
      chk(ack, 32'h0000_0001);
      settle(30);
      chk(ack, 32'h0000_0000);
      @(posedge clk);
      meas.cutoff_tenths <= 7'h64;
      period <= 16'h0FA0;
      cfg_load();
      settle(12000);
      chk({flow, cut, dv, dc}, {24'h00_0000, 1'b1, 16'h0000, 16'h3333});
      @(posedge clk);
      period <= 16'h076C;
      settle(6000);
      chk(cut, 32'h0000_0001);
      @(posedge clk);
      period <= 16'h03E8;
      settle(4000);
      chk({flow, cut, dv, dc}, {24'h1E_8480, 1'b0, 16'h1234, 16'h5678});
      @(posedge clk);
      sela <= fpt_pkg::SRC_MANUAL;
      selb <= fpt_pkg::SRC_DIAG;
      alm.diag <= 16'h0001;
      cfg_load();
      chk(iso, 32'h0000_0003);
      @(posedge clk);
      sela <= fpt_pkg::SRC_FLOW_LO;
      cfg_load();
      chk(iso, 32'h0000_0003);
      @(posedge clk);
      sela <= fpt_pkg::SRC_NONE;
      alm.diag <= 16'h0000;
      cfg_load();
      chk(iso, 32'h0000_0000);
      @(posedge clk);
      sela <= fpt_pkg::SRC_TEMP_RANGE;
      selb <= fpt_pkg::SRC_FLOW_HI;
      alm.rtd_fitted <= 1'b1;
      alm.flow_hi <= 1'b1;
      cfg_load();
      chk(iso, 32'h0000_0003);
      @(posedge clk);
      alm.rtd_fitted <= 1'b0;
      settle(3);
      chk(iso, 32'h0000_0002);
      // Load right after a pulse edge so the flushed history refills on known edges
      @(posedge clk);
      meas.cutoff_tenths <= 7'h00;
      meas.damping_s <= 7'h05;
      meas.samples <= 6'h04;
      @(posedge pulse);
      cfg_load();
      settle(997);
      chk(flow, 32'h0007_A120);
      settle(1000);
      chk(flow, 32'h000F_4240);
      @(posedge clk);
      meas.mode <= fpt_pkg::MEAS_COUNT;
      meas.interval_ms <= 16'h0064;
      meas.samples <= 6'h20;
      period <= 16'h0190;
      cfg_load();
      settle(7000);
      chk(flow, 32'h0000_03E8);
      // Enable low must freeze the window and swallow the accept press
      @(posedge clk);
      ena <= 1'b0;
      period <= 16'h00C8;
      press();
      settle(3000);
      chk({flow, conf}, {24'h00_03E8, 1'b0});
      @(posedge clk);
      ena <= 1'b1;
      settle(5000);
      chk(flow, 32'h0000_07D0);
      close_out();
   end
endmodule
